// ---- hdl/cgi_defs.svh ----
/*
 * Register offsets, field positions, reset values and widths of the CAN
 * general status and interrupt block.
 * Assumes a 32-bit classic Wishbone slave with byte addressing.
 */
`ifndef CGI_DEFS_SVH
`define CGI_DEFS_SVH

`define CGI_NUM_OBJ 15
`define CGI_ADR_W 8

// Byte offsets
`define CGI_OFF_STATUS 8'h00
`define CGI_OFF_FLAGS 8'h04
`define CGI_OFF_ENABLES 8'h08
`define CGI_OFF_INUSE_LO 8'h0C
`define CGI_OFF_INUSE_HI 8'h10
`define CGI_OFF_OBJIE_LO 8'h14
`define CGI_OFF_OBJIE_HI 8'h18
`define CGI_OFF_PEND_LO 8'h1C
`define CGI_OFF_PEND_HI 8'h20
`define CGI_OFF_BT1 8'h24

// General status fields
`define CGI_ST_ENABLED 2
`define CGI_ST_BUSOFF 1
`define CGI_ST_ERROR_PASSIVE_STATE 0

// General flag fields
`define CGI_FL_SUMMARY 7
`define CGI_FL_BUSOFF 6
`define CGI_FL_TWRAP 5
`define CGI_FL_BUFFER 4
`define CGI_FL_STUFF 3
`define CGI_FL_CRC 2
`define CGI_FL_FORM 1
`define CGI_FL_ACK 0

// General enable fields
`define CGI_EN_GLOBAL 7
`define CGI_EN_BUSOFF 6
`define CGI_EN_RX 5
`define CGI_EN_TX 4
`define CGI_EN_OBJERR 3
`define CGI_EN_BUFFER 2
`define CGI_EN_GENERR 1
`define CGI_EN_TWRAP 0

// Prescaler field sits in bits 6:1 of the bit timing register
`define CGI_BRP_LSB 1
`define CGI_BRP_W 6

// Reset values
`define CGI_RST_BYTE 8'h00
`define CGI_RST_OBJ 15'h0000
`define CGI_RST_BRP 6'h00

`endif

// ---- hdl/cgi_pkg.sv ----
/*
 * Types of the CAN general status and interrupt block.
 * Assumes cgi_defs.svh is on the include path.
 */
`include "cgi_defs.svh"

package cgi_pkg;

    typedef logic [`CGI_NUM_OBJ-1:0] cgi_obj_t;

    typedef struct packed {
        logic wb_ack;
        logic [31:0] wb_dat;
        logic enabled;
        logic bus_off;
        logic err_passive;
        logic [6:0] flags;
        logic [7:0] enables;
        cgi_obj_t in_use;
        cgi_obj_t obj_ie;
        cgi_obj_t pending;
        logic [`CGI_BRP_W-1:0] baud_prescale_field;
        logic [`CGI_BRP_W-1:0] tq_cnt;
        logic tq_tick;
        logic irq_can;
        logic irq_timer;
    } cgi_state_t;

endpackage

// ---- hdl/cgi_status_irq.sv ----
/*
 * CAN general status, general interrupt flags and enables, per-object
 * in-use, interrupt enable and pending bits, and the baud prescaler.
 * Assumes the protocol engine drives its event inputs as one-cycle
 * pulses synchronous to clock, its state inputs as levels, and that
 * software reaches the registers over classic Wishbone.
 */
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "cgi_defs.svh"

// What this block does
// - Enabled flag follows the engine's actual enable state, not the command.
// - Bus-off state bit reads 1 while bus-off; only entry raises its flag.
// - Error-passive state bit reads 1 while error passive; no interrupt.
// - Read-only summary bit is OR of all sources except timer wrap.
// - Bus-off flag sets on entry from error passive; write 1 clears.
// - Timer wrap flag sets on wrap; cleared by write 1 or handler entry.
// - Buffer-done flag sets on buffer receive; clear needs all configs rewritten.
// - Stuff error flag sets on stuff violation; write 1 clears.
// - CRC error flag sets on CRC mismatch; write 1 clears.
// - Form error flag sets on fixed-form violation; write 1 clears.
// - Acknowledge error flag sets on missing dominant ack; write 1 clears.
// - Global enable gates the summary interrupt; timer wrap unaffected.
// - Separate enables for bus-off, rx, tx, object errors, buffer, general errors.
// - Timer wrap enable works alone, independent of the global enable.
// - Fifteen read-only in-use bits set when an object is configured enabled.
// - In-use clears on tx done, rx done without auto reply, configure disabled, abort or standby entry.
// - Fifteen read/write per-object interrupt enables, reset to zero.
// - Fifteen read-only per-object pending bits, reset to zero.
// - Scaled clock period is prescaler field plus one clock periods.
// - Object pending sets on rx, tx or error event with object and category enables set.
// - Writing 0 to a general flag leaves it unchanged.
// - Object errors set only object status, never the general error flags.
module cgi_status_irq
    import cgi_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic sw_reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`CGI_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic ctl_enabled,
    input wire logic bus_off,
    input wire logic err_passive,
    input wire logic abort_req,
    input wire logic timer_wrap,
    input wire logic timer_irq_enter,
    input wire logic buf_rx_done,
    input wire logic buf_cfg_rewritten,
    input wire logic gen_stuff_err,
    input wire logic gen_crc_err,
    input wire logic gen_form_err,
    input wire logic gen_ack_err,
    input wire logic [`CGI_NUM_OBJ-1:0] obj_rx_done,
    input wire logic [`CGI_NUM_OBJ-1:0] obj_tx_done,
    input wire logic [`CGI_NUM_OBJ-1:0] obj_err,
    input wire logic [`CGI_NUM_OBJ-1:0] obj_auto_reply,
    input wire logic [`CGI_NUM_OBJ-1:0] obj_cfg_enable,
    input wire logic [`CGI_NUM_OBJ-1:0] obj_cfg_disable,
    input wire logic [`CGI_NUM_OBJ-1:0] obj_irq_ack,
    output logic tq_tick,
    output logic irq_can,
    output logic irq_timer
);

    cgi_state_t st_r;
    cgi_state_t st_nxt;

    logic req;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [7:0] w1c;
    logic any_obj_err;
    logic standby_entry;
    logic summary;
    logic [7:0] flags_rd;
    logic [`CGI_NUM_OBJ-1:0] in_use_set;
    logic [`CGI_NUM_OBJ-1:0] in_use_clr;
    logic [`CGI_NUM_OBJ-1:0] pend_set;

    assign req = wb_cyc_i & wb_stb_i & ~st_r.wb_ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign any_obj_err = |obj_err;
    assign standby_entry = st_r.enabled & ~ctl_enabled;

    // Per-object set and clear terms
    genvar gi;
    generate
        for (gi = 0; gi < `CGI_NUM_OBJ; gi = gi + 1) begin : g_obj
            assign in_use_set[gi] = obj_cfg_enable[gi];
            assign in_use_clr[gi] = obj_tx_done[gi]
                | (obj_rx_done[gi] & ~obj_auto_reply[gi])
                | obj_cfg_disable[gi] | abort_req | standby_entry;
            assign pend_set[gi] = st_r.obj_ie[gi]
                & ((obj_rx_done[gi] & st_r.enables[`CGI_EN_RX])
                | (obj_tx_done[gi] & st_r.enables[`CGI_EN_TX])
                | (obj_err[gi] & st_r.enables[`CGI_EN_OBJERR]));
        end
    endgenerate

    // Summary of all sources but the timer wrap
    always_comb begin
        summary = (|st_r.pending)
            | (st_r.flags[`CGI_FL_BUSOFF] & st_r.enables[`CGI_EN_BUSOFF])
            | (st_r.flags[`CGI_FL_BUFFER] & st_r.enables[`CGI_EN_BUFFER])
            | ((|st_r.flags[`CGI_FL_STUFF:`CGI_FL_ACK])
            & st_r.enables[`CGI_EN_GENERR]);
        flags_rd = {summary, st_r.flags};
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (wb_adr_i)
            `CGI_OFF_STATUS: rbyte = {5'h00, st_r.enabled, st_r.bus_off, st_r.err_passive};
            `CGI_OFF_FLAGS: rbyte = flags_rd;
            `CGI_OFF_ENABLES: rbyte = st_r.enables;
            `CGI_OFF_INUSE_LO: rbyte = st_r.in_use[7:0];
            `CGI_OFF_INUSE_HI: rbyte = {1'b0, st_r.in_use[14:8]};
            `CGI_OFF_OBJIE_LO: rbyte = st_r.obj_ie[7:0];
            `CGI_OFF_OBJIE_HI: rbyte = {1'b0, st_r.obj_ie[14:8]};
            `CGI_OFF_PEND_LO: rbyte = st_r.pending[7:0];
            `CGI_OFF_PEND_HI: rbyte = {1'b0, st_r.pending[14:8]};
            `CGI_OFF_BT1: rbyte = {1'b0, st_r.baud_prescale_field, 1'b0};
            default: rbyte = `CGI_RST_BYTE;
        endcase
    end

    // Write-one-to-clear mask for the flag register
    always_comb begin
        w1c = `CGI_RST_BYTE;
        if (wr && wb_adr_i == `CGI_OFF_FLAGS) begin
            w1c = wbyte;
        end
        if (!buf_cfg_rewritten) begin
            w1c[`CGI_FL_BUFFER] = 1'b0;
        end
        if (timer_irq_enter) begin
            w1c[`CGI_FL_TWRAP] = 1'b1;
        end
    end

    always_comb begin
        st_nxt = st_r;

        // Bus slave: one wait state, ack dropped the cycle after
        st_nxt.wb_ack = req;
        if (req) begin
            st_nxt.wb_dat = {24'h00_0000, rbyte};
        end

        // Engine state images
        st_nxt.enabled = ctl_enabled;
        st_nxt.bus_off = bus_off;
        st_nxt.err_passive = err_passive;

        // General flags: clear first, set wins
        st_nxt.flags = st_r.flags & ~w1c[6:0];
        if (bus_off && !st_r.bus_off && st_r.err_passive) begin
            st_nxt.flags[`CGI_FL_BUSOFF] = 1'b1;
        end
        if (timer_wrap) begin
            st_nxt.flags[`CGI_FL_TWRAP] = 1'b1;
        end
        if (buf_rx_done) begin
            st_nxt.flags[`CGI_FL_BUFFER] = 1'b1;
        end
        if (!any_obj_err) begin
            if (gen_stuff_err) begin
                st_nxt.flags[`CGI_FL_STUFF] = 1'b1;
            end
            if (gen_crc_err) begin
                st_nxt.flags[`CGI_FL_CRC] = 1'b1;
            end
            if (gen_form_err) begin
                st_nxt.flags[`CGI_FL_FORM] = 1'b1;
            end
            if (gen_ack_err) begin
                st_nxt.flags[`CGI_FL_ACK] = 1'b1;
            end
        end

        // Software-written registers
        if (wr) begin
            case (wb_adr_i)
                `CGI_OFF_ENABLES: st_nxt.enables = wbyte;
                `CGI_OFF_OBJIE_LO: st_nxt.obj_ie[7:0] = wbyte;
                `CGI_OFF_OBJIE_HI: st_nxt.obj_ie[14:8] = wbyte[6:0];
                `CGI_OFF_BT1: st_nxt.baud_prescale_field = wbyte[`CGI_BRP_LSB +: `CGI_BRP_W];
                default: st_nxt.enables = st_r.enables;
            endcase
        end

        // Object bookkeeping, set wins over clear
        st_nxt.in_use = (st_r.in_use & ~in_use_clr) | in_use_set;
        st_nxt.pending = (st_r.pending & ~obj_irq_ack) | pend_set;

        // Prescaler: one tick every brp+1 clocks
        if (st_r.tq_cnt >= st_r.baud_prescale_field) begin
            st_nxt.tq_cnt = `CGI_RST_BRP;
            st_nxt.tq_tick = 1'b1;
        end else begin
            st_nxt.tq_cnt = st_r.tq_cnt + 6'h01;
            st_nxt.tq_tick = 1'b0;
        end

        // Interrupt requests
        st_nxt.irq_can = summary & st_r.enables[`CGI_EN_GLOBAL];
        st_nxt.irq_timer = st_r.flags[`CGI_FL_TWRAP]
            & st_r.enables[`CGI_EN_TWRAP];

        // Controller software reset clears all but the bus handshake
        if (sw_reset) begin
            st_nxt = '0;
            st_nxt.wb_ack = req;
            st_nxt.wb_dat = st_r.wb_dat;
            if (req) begin
                st_nxt.wb_dat = {24'h00_0000, rbyte};
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.wb_ack;
    assign wb_dat_o = st_r.wb_dat;
    assign tq_tick = st_r.tq_tick;
    assign irq_can = st_r.irq_can;
    assign irq_timer = st_r.irq_timer;

endmodule

// ---- verification/cgi_engine_model.sv ----
/* Stand-in for the CAN protocol engine: bench commands become event pulses and levels.
   Assumes commands change just after a rising edge of clock and last one cycle. */
`timescale 1ns/1ps
module cgi_engine_model (
    input wire logic clock,
    input wire logic [3:0] cmd,
    input wire logic [3:0] idx,
    output logic [7:0] ev,
    output logic [3:0] lv,
    output logic [5:0][14:0] ob
);
    initial begin
        ev = '0;
        lv = '0;
        ob = '0;
    end
    // One-cycle pulses; command 15 loads the state levels
    always @(posedge clock) begin
        ev <= '0;
        ob <= '0;
        if (cmd inside {[1:8]}) ev[cmd - 4'h1] <= 1'b1;
        if (cmd inside {[9:14]}) ob[cmd - 4'h9][idx] <= 1'b1;
        if (cmd == 4'hf) lv <= idx;
    end
endmodule

// ---- verification/cgi_status_irq_checker.sv ----
/* Concurrent checks on the ports of the CAN status and interrupt block.
   Assumes one clock domain and the byte offsets of cgi_defs.svh. */
`timescale 1ns/1ps
`include "cgi_defs.svh"
module cgi_status_irq_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sw_reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`CGI_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic ctl_enabled,
    input wire logic bus_off,
    input wire logic err_passive,
    input wire logic timer_irq_enter,
    input wire logic timer_wrap,
    input wire logic tq_tick,
    input wire logic irq_can,
    input wire logic irq_timer
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wen = take && wb_we_i && wb_sel_i[0];
    logic [5:0] brp_m;
    logic [7:0] cnt;
    logic [7:0] qt;
    // Prescaler mirror and tick spacing counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            brp_m <= 6'h00;
            cnt <= 8'h00;
            qt <= 8'h00;
        end else begin
            cnt <= tq_tick ? 8'h00 : cnt + 8'h01;
            if (sw_reset || (wen && wb_adr_i == `CGI_OFF_BT1)) begin
                brp_m <= sw_reset ? 6'h00 : wb_dat_i[6:1];
                qt <= 8'h00;
            end else if (qt != 8'hff) begin
                qt <= qt + 8'h01;
            end
        end
    end
    a_ack_one_wait: assert property (
        take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
    a_ack_needs_req: assert property (
        !take |=> !wb_ack_o) else $error("ack without a request");
    a_tick_period: assert property (
        qt > 8'h8c |-> tq_tick == (cnt == {2'b00, brp_m})) else $error("prescaler tick spacing");
    a_timer_clear_entry: assert property (
        timer_irq_enter && !timer_wrap |-> ##2 !irq_timer) else $error("timer irq after entry");
    a_global_gate_off: assert property (
        wen && wb_adr_i == `CGI_OFF_ENABLES && !wb_dat_i[7] |-> ##2 !irq_can)
        else $error("irq with global enable off");
    a_timer_gate_off: assert property (
        wen && wb_adr_i == `CGI_OFF_ENABLES && !wb_dat_i[0] |-> ##2 !irq_timer)
        else $error("timer irq with its enable off");
    a_status_image: assert property (
        take && !wb_we_i && wb_adr_i == `CGI_OFF_STATUS && !$past(sw_reset)
        |=> wb_dat_o[2:0] == {$past(ctl_enabled, 2), $past(bus_off, 2), $past(err_passive, 2)})
        else $error("status image wrong");
    a_sw_reset_quiet: assert property (
        sw_reset |-> ##2 !irq_can && !irq_timer) else $error("irq after soft reset");
endmodule
bind cgi_status_irq cgi_status_irq_checker chk (.clock, .rstn, .sw_reset, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .ctl_enabled, .bus_off,
    .err_passive, .timer_irq_enter, .timer_wrap, .tq_tick, .irq_can, .irq_timer);

// ---- verification/test_cgi_status_irq.sv ----
/* Self-checking bench for the CAN status and interrupt block.
   Assumes the engine stand-in and the checker are compiled before it. */
`timescale 1ns/1ps
`include "cgi_defs.svh"
module test_cgi_status_irq;
    localparam logic [7:0] o_fl = `CGI_OFF_FLAGS;
    localparam logic [7:0] o_en = `CGI_OFF_ENABLES;
    logic clock = 1'b0, rstn = 1'b0, sw_reset = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic wb_ack_o, tq_tick, irq_can, irq_timer;
    logic [7:0] wb_adr_i = 8'h00, r;
    logic [3:0] wb_sel_i = 4'hf, cmd = 4'h0, idx = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic [7:0] ev;
    logic [3:0] lv;
    logic [5:0][14:0] ob;
    logic [3:0] clr[4] = '{4'h9, 4'ha, 4'hd, 4'h8};
    logic [14:0] auto_rep = 15'h0000, err_x = 15'h0000;
    logic [9:0] exp_q[$];
    int err_total = 0, check_count = 0, cycles = 0, seed = 32'h0000_da80;
    always #50 clock = ~clock;
    cgi_engine_model eng (.clock, .cmd, .idx, .ev, .lv, .ob);
    cgi_status_irq dut (.clock, .rstn, .sw_reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .ctl_enabled(lv[0]), .bus_off(lv[1]),
        .err_passive(lv[2]), .buf_cfg_rewritten(lv[3]), .timer_wrap(ev[0]),
        .timer_irq_enter(ev[1]), .buf_rx_done(ev[2]), .gen_stuff_err(ev[3]),
        .gen_crc_err(ev[4]), .gen_form_err(ev[5]), .gen_ack_err(ev[6]), .abort_req(ev[7]),
        .obj_rx_done(ob[0]), .obj_tx_done(ob[1]), .obj_err(ob[2] | err_x),
        .obj_cfg_enable(ob[3]), .obj_cfg_disable(ob[4]), .obj_irq_ack(ob[5]),
        .obj_auto_reply(auto_rep), .tq_tick,
        .irq_can, .irq_timer);
    task check(input logic [9:0] seen, input logic [9:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task complete_run();
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [9:0] e);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        if (!w) exp_q.push_back(e);
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 10'h000);
    endtask
    task rd(input logic [7:0] a, input logic [9:0] e);
        bus(a, 1'b0, 8'h00, e);
    endtask
    task pulse(input logic [3:0] c, input logic [3:0] i);
        @(posedge clock);
        cmd <= c;
        idx <= i;
        @(posedge clock);
        cmd <= 4'h0;
        repeat (3) @(posedge clock);
    endtask
    // Result monitor and run limit
    always @(posedge clock) begin
        cycles++;
        if (cycles == 32'h0000_4e20) begin
            err_total++;
            complete_run();
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            check({irq_timer, irq_can, wb_dat_o[7:0]}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 0; a <= 40; a += 4) rd(8'(a), 10'h000);
        repeat (4) begin
            r = 8'($random(seed));
            wr(`CGI_OFF_OBJIE_HI, r & 8'h7f);
            rd(`CGI_OFF_OBJIE_HI, {2'b00, r & 8'h7f});
            wr(`CGI_OFF_BT1, r & 8'h7e);
            rd(`CGI_OFF_BT1, {2'b00, r & 8'h7e});
            wr(o_en, r & 8'h7e);
            rd(o_en, {2'b00, r & 8'h7e});
        end
        repeat (200) @(posedge clock);
        wr(o_en, 8'h86);
        for (int i = 0; i < 4; i++) begin
            pulse(4'(i + 4), 4'h0);
            rd(o_fl, {2'b01, 8'h80 | (8'h08 >> i)});
            wr(o_fl, 8'h00);
            rd(o_fl, {2'b01, 8'h80 | (8'h08 >> i)});
            wr(o_fl, 8'h08 >> i);
            rd(o_fl, 10'h000);
        end
        pulse(4'h3, 4'h0);
        wr(o_fl, 8'h10);
        rd(o_fl, {2'b01, 8'h90});
        pulse(4'hf, 4'h8);
        wr(o_fl, 8'h10);
        rd(o_fl, 10'h000);
        wr(o_en, 8'h03);
        pulse(4'h4, 4'h0);
        rd(o_fl, {2'b00, 8'h88});
        pulse(4'h1, 4'h0);
        rd(o_fl, {2'b10, 8'ha8});
        pulse(4'h2, 4'h0);
        rd(o_fl, {2'b00, 8'h88});
        wr(o_fl, 8'h08);
        pulse(4'hf, 4'h9);
        rd(`CGI_OFF_STATUS, 10'h004);
        pulse(4'hf, 4'hb);
        rd(`CGI_OFF_STATUS, 10'h006);
        rd(o_fl, 10'h000);
        pulse(4'hf, 4'hd);
        rd(`CGI_OFF_STATUS, 10'h005);
        pulse(4'hf, 4'hf);
        wr(o_en, 8'hc0);
        rd(o_fl, {2'b01, 8'hc0});
        wr(o_fl, 8'h40);
        rd(o_fl, 10'h000);
        pulse(4'hf, 4'h9);
        wr(o_en, 8'hb8);
        wr(`CGI_OFF_OBJIE_LO, 8'h08);
        wr(`CGI_OFF_OBJIE_HI, 8'h40);
        pulse(4'h9, 4'h3);
        rd(`CGI_OFF_PEND_LO, {2'b01, 8'h08});
        pulse(4'he, 4'h3);
        pulse(4'hb, 4'he);
        rd(`CGI_OFF_PEND_HI, {2'b01, 8'h40});
        @(posedge clock);
        err_x <= 15'h0002;
        pulse(4'h4, 4'h0);
        err_x <= 15'h0000;
        rd(o_fl, {2'b01, 8'h80});
        pulse(4'he, 4'he);
        pulse(4'ha, 4'h5);
        rd(`CGI_OFF_PEND_LO, 10'h000);
        foreach (clr[k]) begin
            pulse(4'hc, 4'(k));
            rd(`CGI_OFF_INUSE_LO, {2'b00, 8'h01 << k});
            pulse(clr[k], 4'(k));
            rd(`CGI_OFF_INUSE_LO, 10'h000);
        end
        auto_rep <= 15'h0010;
        pulse(4'hc, 4'h4);
        pulse(4'h9, 4'h4);
        rd(`CGI_OFF_INUSE_LO, {2'b00, 8'h10});
        pulse(4'ha, 4'h4);
        rd(`CGI_OFF_INUSE_LO, 10'h000);
        auto_rep <= 15'h0000;
        pulse(4'hc, 4'h0);
        pulse(4'hf, 4'h8);
        rd(`CGI_OFF_INUSE_LO, 10'h000);
        @(posedge clock);
        sw_reset <= 1'b1;
        @(posedge clock);
        sw_reset <= 1'b0;
        rd(`CGI_OFF_OBJIE_HI, 10'h000);
        repeat (2) @(posedge clock);
        check(10'(exp_q.size()), 10'h000);
        complete_run();
    end
endmodule
